// [design/eaei_defs.svh]
// Offsets, bit positions, masks and reset values of the alarm interrupt block.
// Assumes a byte-wide register port with a 16-bit address.
`ifndef EAEI_DEFS_SVH
`define EAEI_DEFS_SVH

// ----------------------------------------------------------------------------
// Port widths
// ----------------------------------------------------------------------------
`define EAEI_ADDR_W 16
`define EAEI_DATA_W 8
`define EAEI_CRIT_W 3

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define EAEI_OFS_BLK_STATUS 16'h0b00
`define EAEI_OFS_BLK_ENABLE 16'h0b01
`define EAEI_OFS_EVT_STATUS 16'h0b02
`define EAEI_OFS_EVT_ENABLE 16'h0b03
`define EAEI_OFS_FRM_CTRL 16'h010b

// ----------------------------------------------------------------------------
// Bit positions
// ----------------------------------------------------------------------------
`define EAEI_BIT_YEL_CHG 0
`define EAEI_BIT_AIS_CHG 1
`define EAEI_BIT_OOF_CHG 2
`define EAEI_BIT_LCV 3
`define EAEI_BIT_LOS_STATE 4
`define EAEI_BIT_MYEL_CHG 5
`define EAEI_BIT_AIS_STATE 6
`define EAEI_BIT_OOF_STATE 7
`define EAEI_BIT_YEL_LIVE 7
`define EAEI_BIT_ALARM_BLK 1
`define EAEI_CRIT_HI 2
`define EAEI_CRIT_LO 0

// ----------------------------------------------------------------------------
// Masks and reset values
// ----------------------------------------------------------------------------
`define EAEI_FLAG_MASK 8'h2f
`define EAEI_EN_RW_MASK 8'h3f
`define EAEI_BYTE_ZERO 8'h00
`define EAEI_CRIT_ZERO 3'h0
`define EAEI_THR_ONE 4'h1
`define EAEI_CNT_ZERO 3'h0
`define EAEI_CNT_STEP 4'h1

`endif

// [design/eaei_pkg.sv]
// Types shared by the alarm interrupt block and its yellow alarm detector.
// Assumes eaei_defs.svh is on the include path.
`include "eaei_defs.svh"

package eaei_pkg;

    // ------------------------------------------------------------------------
    // Yellow alarm detector
    // ------------------------------------------------------------------------
    // Clear, clear with one A bit seen, declared, declared with one zero seen
    typedef enum logic [1:0] {YEL_CLEAR, YEL_CLEAR_ONE, YEL_SET, YEL_SET_ZERO} eaei_yel_e;

    // Whole state of the detector
    typedef struct packed {
        eaei_yel_e state; // Filter state
        logic live;       // Alarm currently declared
        logic change;     // One-cycle pulse on declare or clear
    } eaei_yel_s;

    // ------------------------------------------------------------------------
    // Top level
    // ------------------------------------------------------------------------
    // Whole state of the interrupt block
    typedef struct packed {
        logic [`EAEI_DATA_W-1:0] flags;  // Sticky event flags
        logic [`EAEI_DATA_W-1:0] evt_en; // Source-level enables
        logic blk_en;                    // Block-level enable
        logic [`EAEI_CRIT_W-1:0] crit;   // Frame loss criteria
        logic [`EAEI_CRIT_W-1:0] err_cnt; // Consecutive errored patterns
        logic oof;                       // Out-of-frame declared
        logic ais_prev;                  // Last sampled alarm signal state
        logic myel_prev;                 // Last sampled multiframe alarm state
        logic [`EAEI_DATA_W-1:0] rdata;  // Read data register
        logic irq;                       // Interrupt output register
    } eaei_top_s;

endpackage : eaei_pkg

// [design/eaei_yel_detect.sv]
// Remote yellow alarm filter over the A bit of non-alignment frames.
// Assumes one frame_valid pulse per non-alignment frame with a_bit beside it.
`include "eaei_defs.svh"

module eaei_yel_detect
(
    input logic clk,
    input logic rst,
    input logic frame_valid,
    input logic a_bit,
    output logic live,
    output logic change
);

    // Registered state and its next value
    eaei_pkg::eaei_yel_s s_r;
    eaei_pkg::eaei_yel_s s_nxt;

    // ------------------------------------------------------------------------
    // Filter: two equal A bits in a row move the alarm
    // ------------------------------------------------------------------------
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.change = 1'b0;
        if (frame_valid)
        begin
            case (s_r.state)
                eaei_pkg::YEL_CLEAR:
                    s_nxt.state = a_bit ? eaei_pkg::YEL_CLEAR_ONE : eaei_pkg::YEL_CLEAR;
                eaei_pkg::YEL_CLEAR_ONE:
                begin
                    // Second one in a row declares the alarm [R7]
                    if (a_bit)
                    begin
                        s_nxt.state = eaei_pkg::YEL_SET;
                        s_nxt.live = 1'b1;
                        s_nxt.change = 1'b1;
                    end
                    else
                    begin
                        s_nxt.state = eaei_pkg::YEL_CLEAR;
                    end
                end
                eaei_pkg::YEL_SET:
                    s_nxt.state = a_bit ? eaei_pkg::YEL_SET : eaei_pkg::YEL_SET_ZERO;
                default:
                begin
                    // Second zero in a row clears the alarm [R7]
                    if (!a_bit)
                    begin
                        s_nxt.state = eaei_pkg::YEL_CLEAR;
                        s_nxt.live = 1'b0;
                        s_nxt.change = 1'b1;
                    end
                    else
                    begin
                        s_nxt.state = eaei_pkg::YEL_SET;
                    end
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign live = s_r.live;
    assign change = s_r.change;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    a_yel_declare_two: assert property ( // [R7]
        @(posedge clk) disable iff (rst)
        (s_r.state == eaei_pkg::YEL_CLEAR_ONE && frame_valid && a_bit) |=> live && change)
        else $error("yellow alarm not declared after two ones");

    a_yel_rise_cause: assert property ( // [R7]
        @(posedge clk) disable iff (rst)
        $rose(live) |-> $past(frame_valid && a_bit && s_r.state == eaei_pkg::YEL_CLEAR_ONE))
        else $error("yellow alarm declared without two ones");

endmodule : eaei_yel_detect

// [design/eaei_top.sv]
// Alarm and error interrupt block of the E1 receive framer.
// Assumes a byte register port with read data one cycle after the strobe,
// and event inputs synchronous to REF_CLK.
//
// Implementation choice: the plain strobed port.
`include "eaei_defs.svh"

// Operation
// R1 - Line violation sets status bit three
// R2 - Event flags hold until status read; a write of ones to the status register also clears them
// R3 - Frame loss change sets bit two
// R4 - Frame loss after programmed errored patterns
// R5 - Alarm signal change sets bit one
// R6 - Remote alarm change sets bit zero
// R7 - Remote alarm needs two equal A bits
// R8 - Enable bit seven shows live remote alarm
// R9 - Enable bit five gates multiframe alarm
// R10 - Software keeps enable bit four zero
// R11 - Enable bit three gates line violation
// R12 - Enable bit two gates frame loss
// R13 - Enable bit one gates alarm signal
// R14 - Enable bit zero gates remote alarm
// R15 - Block status bit one shows pending
// R16 - Block enable bit one masks group
// R17 - Request is OR of flag-enable terms
// R18 - Event beside clearing read stays latched
module eaei_top
(
    input logic REF_CLK,
    input logic RST,
    input logic [`EAEI_ADDR_W-1:0] ADDR,
    input logic [`EAEI_DATA_W-1:0] WDATA,
    input logic WR,
    input logic RD,
    output logic [`EAEI_DATA_W-1:0] RDATA,
    output logic IRQ,
    input logic LCV_DETECT,
    input logic FAS_CHECK,
    input logic FAS_ERROR,
    input logic NFAS_FRAME,
    input logic NFAS_A_BIT,
    input logic RX_AIS_STATE,
    input logic RX_MYEL_STATE,
    input logic RX_LOS_STATE,
    output logic OOF_STATE,
    output logic YEL_STATE
);

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    eaei_pkg::eaei_top_s s_r;                 // Registered state
    eaei_pkg::eaei_top_s s_nxt;               // Next state
    logic yel_live;                           // Remote alarm declared
    logic yel_change;                         // Remote alarm moved
    logic ais_change;                         // Alarm signal moved
    logic myel_change;                        // Multiframe alarm moved
    logic oof_change;                         // Frame loss moved
    logic [`EAEI_DATA_W-1:0] set_vec;         // Flags set this cycle
    logic [`EAEI_DATA_W-1:0] clr_vec;         // Flags cleared this cycle
    logic [`EAEI_DATA_W-1:0] evt_rd_view;     // Status register as read
    logic [`EAEI_DATA_W-1:0] en_rd_view;      // Enable register as read
    logic [`EAEI_DATA_W-1:0] blk_rd_view;     // Block status as read
    logic [`EAEI_DATA_W-1:0] blk_en_view;     // Block enable as read
    logic [`EAEI_DATA_W-1:0] frm_rd_view;     // Framing control as read
    logic [`EAEI_CRIT_W:0] thresh;            // Errored patterns to declare
    logic [`EAEI_CRIT_W:0] cnt_inc;           // Count after one more error
    logic pending;                            // Any unmasked flag set
    logic pending_nxt;                        // Same, from next state
    logic rd_evt;                             // Read of the status register
    logic wr_evt;                             // Write to the status register

    // ------------------------------------------------------------------------
    // Remote alarm detector
    // ------------------------------------------------------------------------
    eaei_yel_detect u_yel
    (
        .clk(REF_CLK),
        .rst(RST),
        .frame_valid(NFAS_FRAME),
        .a_bit(NFAS_A_BIT),
        .live(yel_live),
        .change(yel_change)
    );

    // ------------------------------------------------------------------------
    // Event and register views
    // ------------------------------------------------------------------------
    // Edge detectors, access decode and read views of the registers
    always_comb
    begin
        // Level inputs move either way: both edges count
        ais_change = RX_AIS_STATE ^ s_r.ais_prev;
        myel_change = RX_MYEL_STATE ^ s_r.myel_prev;
        rd_evt = RD && (ADDR == `EAEI_OFS_EVT_STATUS);
        wr_evt = WR && (ADDR == `EAEI_OFS_EVT_STATUS);
        // Group request is the OR of every flag with its enable [R17]
        pending = |(s_r.flags & s_r.evt_en & `EAEI_FLAG_MASK);
        // Status view: live states beside the sticky flags
        evt_rd_view = s_r.flags & `EAEI_FLAG_MASK;
        evt_rd_view[`EAEI_BIT_OOF_STATE] = s_r.oof;
        evt_rd_view[`EAEI_BIT_AIS_STATE] = RX_AIS_STATE;
        evt_rd_view[`EAEI_BIT_LOS_STATE] = RX_LOS_STATE;
        // Enable view: bit seven is the live remote alarm, six reads zero [R8]
        en_rd_view = s_r.evt_en & `EAEI_EN_RW_MASK;
        en_rd_view[`EAEI_BIT_YEL_LIVE] = yel_live;
        // Block status shows the pending group request [R15]
        blk_rd_view = `EAEI_BYTE_ZERO;
        blk_rd_view[`EAEI_BIT_ALARM_BLK] = pending;
        blk_en_view = `EAEI_BYTE_ZERO;
        blk_en_view[`EAEI_BIT_ALARM_BLK] = s_r.blk_en;
        frm_rd_view = `EAEI_BYTE_ZERO;
        frm_rd_view[`EAEI_CRIT_HI:`EAEI_CRIT_LO] = s_r.crit;
        // A zero criteria is taken as one errored pattern
        thresh = {1'b0, s_r.crit};
        if (s_r.crit == `EAEI_CRIT_ZERO)
        begin
            thresh = `EAEI_THR_ONE;
        end
        cnt_inc = {1'b0, s_r.err_cnt} + `EAEI_CNT_STEP;
    end

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    // Frame loss tracking, flag update, register writes and read data
    always_comb
    begin
        s_nxt = s_r;
        oof_change = 1'b0;
        s_nxt.ais_prev = RX_AIS_STATE;
        s_nxt.myel_prev = RX_MYEL_STATE;

        // Frame loss: consecutive errored alignment patterns
        if (FAS_CHECK)
        begin
            if (FAS_ERROR)
            begin
                if (!s_r.oof)
                begin
                    // Declare once the programmed count is reached [R4]
                    if (cnt_inc >= thresh)
                    begin
                        s_nxt.oof = 1'b1;
                        s_nxt.err_cnt = `EAEI_CNT_ZERO;
                        oof_change = 1'b1;
                    end
                    else
                    begin
                        s_nxt.err_cnt = cnt_inc[`EAEI_CRIT_W-1:0];
                    end
                end
            end
            else
            begin
                // A good pattern breaks the run and ends frame loss
                s_nxt.err_cnt = `EAEI_CNT_ZERO;
                if (s_r.oof)
                begin
                    s_nxt.oof = 1'b0;
                    oof_change = 1'b1;
                end
            end
        end

        // Events that set flags
        set_vec = `EAEI_BYTE_ZERO;
        // Line violation latches whatever its enable [R1]
        set_vec[`EAEI_BIT_LCV] = LCV_DETECT;
        // Frame loss change, gated by its enable [R3] [R12]
        set_vec[`EAEI_BIT_OOF_CHG] = oof_change && s_r.evt_en[`EAEI_BIT_OOF_CHG];
        // Alarm signal change, gated by its enable [R5] [R13]
        set_vec[`EAEI_BIT_AIS_CHG] = ais_change && s_r.evt_en[`EAEI_BIT_AIS_CHG];
        // Remote alarm change, gated by its enable [R6] [R14]
        set_vec[`EAEI_BIT_YEL_CHG] = yel_change && s_r.evt_en[`EAEI_BIT_YEL_CHG];
        // Multiframe alarm change, gated by its enable [R9]
        set_vec[`EAEI_BIT_MYEL_CHG] = myel_change && s_r.evt_en[`EAEI_BIT_MYEL_CHG];

        // Clearing: a read clears all flags, a write clears the ones written
        clr_vec = `EAEI_BYTE_ZERO;
        if (rd_evt)
        begin
            clr_vec = `EAEI_FLAG_MASK; // [R2]
        end
        else if (wr_evt)
        begin
            clr_vec = WDATA & `EAEI_FLAG_MASK;
        end

        // Set wins over clear in the same cycle [R2] [R18]
        s_nxt.flags = ((s_r.flags & ~clr_vec) | set_vec) & `EAEI_FLAG_MASK;

        // Register writes
        if (WR)
        begin
            if (ADDR == `EAEI_OFS_BLK_ENABLE)
            begin
                s_nxt.blk_en = WDATA[`EAEI_BIT_ALARM_BLK]; // [R16]
            end
            else if (ADDR == `EAEI_OFS_EVT_ENABLE)
            begin
                // Bits five to zero store; seven and six ignore writes [R11]
                s_nxt.evt_en = WDATA & `EAEI_EN_RW_MASK;
            end
            else if (ADDR == `EAEI_OFS_FRM_CTRL)
            begin
                s_nxt.crit = WDATA[`EAEI_CRIT_HI:`EAEI_CRIT_LO]; // [R4]
            end
        end

        // Read data stands only in the cycle after the strobe
        s_nxt.rdata = `EAEI_BYTE_ZERO;
        if (RD)
        begin
            if (ADDR == `EAEI_OFS_BLK_STATUS)
            begin
                s_nxt.rdata = blk_rd_view;
            end
            else if (ADDR == `EAEI_OFS_BLK_ENABLE)
            begin
                s_nxt.rdata = blk_en_view;
            end
            else if (ADDR == `EAEI_OFS_EVT_STATUS)
            begin
                s_nxt.rdata = evt_rd_view;
            end
            else if (ADDR == `EAEI_OFS_EVT_ENABLE)
            begin
                s_nxt.rdata = en_rd_view;
            end
            else if (ADDR == `EAEI_OFS_FRM_CTRL)
            begin
                s_nxt.rdata = frm_rd_view;
            end
        end

        // Interrupt output from the next state, masked at block level [R16] [R17]
        pending_nxt = |(s_nxt.flags & s_nxt.evt_en & `EAEI_FLAG_MASK);
        s_nxt.irq = s_nxt.blk_en && pending_nxt;
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    // Every bit clears under reset
    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign RDATA = s_r.rdata;
    assign IRQ = s_r.irq;
    assign OOF_STATE = s_r.oof;
    assign YEL_STATE = yel_live;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    a_lcv_flag_set: assert property ( // [R1]
        @(posedge REF_CLK) disable iff (RST)
        LCV_DETECT |=> s_r.flags[`EAEI_BIT_LCV])
        else $error("line violation did not set its flag");

    a_read_clears_flags: assert property ( // [R2]
        @(posedge REF_CLK) disable iff (RST)
        (rd_evt && set_vec == `EAEI_BYTE_ZERO) |=> s_r.flags == `EAEI_BYTE_ZERO)
        else $error("status read did not clear the flags");

    a_flags_hold_set: assert property ( // [R2]
        @(posedge REF_CLK) disable iff (RST)
        (!rd_evt && !wr_evt) |=> ((s_r.flags & $past(s_r.flags)) == $past(s_r.flags)))
        else $error("flag dropped without a clear");

    a_oof_flag_set: assert property ( // [R3]
        @(posedge REF_CLK) disable iff (RST)
        (oof_change && s_r.evt_en[`EAEI_BIT_OOF_CHG]) |=> s_r.flags[`EAEI_BIT_OOF_CHG])
        else $error("frame loss change not latched");

    a_oof_declare_count: assert property ( // [R4]
        @(posedge REF_CLK) disable iff (RST)
        (FAS_CHECK && FAS_ERROR && !s_r.oof && cnt_inc >= thresh) |=> OOF_STATE)
        else $error("frame loss not declared at the programmed count");

    a_oof_rise_cause: assert property ( // [R4]
        @(posedge REF_CLK) disable iff (RST)
        $rose(OOF_STATE) |-> $past(FAS_CHECK && FAS_ERROR && cnt_inc >= thresh))
        else $error("frame loss declared early");

    a_ais_flag_set: assert property ( // [R5]
        @(posedge REF_CLK) disable iff (RST)
        (ais_change && s_r.evt_en[`EAEI_BIT_AIS_CHG]) |=> s_r.flags[`EAEI_BIT_AIS_CHG])
        else $error("alarm signal change not latched");

    a_yel_flag_set: assert property ( // [R6]
        @(posedge REF_CLK) disable iff (RST)
        (yel_change && s_r.evt_en[`EAEI_BIT_YEL_CHG]) |=> s_r.flags[`EAEI_BIT_YEL_CHG])
        else $error("remote alarm change not latched");

    a_yel_live_read: assert property ( // [R8]
        @(posedge REF_CLK) disable iff (RST)
        (RD && ADDR == `EAEI_OFS_EVT_ENABLE) |=> RDATA[`EAEI_BIT_YEL_LIVE] == $past(yel_live))
        else $error("enable read does not show the live remote alarm");

    a_myel_flag_gate: assert property ( // [R9]
        @(posedge REF_CLK) disable iff (RST)
        (myel_change && !s_r.evt_en[`EAEI_BIT_MYEL_CHG] && !s_r.flags[`EAEI_BIT_MYEL_CHG])
        |=> !s_r.flags[`EAEI_BIT_MYEL_CHG])
        else $error("disabled multiframe alarm change latched");

    a_blk_status_read: assert property ( // [R15]
        @(posedge REF_CLK) disable iff (RST)
        (RD && ADDR == `EAEI_OFS_BLK_STATUS) |=> RDATA[`EAEI_BIT_ALARM_BLK] == $past(pending))
        else $error("block status does not show the pending request");

    a_irq_level_tie: assert property ( // [R16] [R17]
        @(posedge REF_CLK) disable iff (RST)
        ##1 IRQ == (s_r.blk_en && pending))
        else $error("interrupt output disagrees with flags and enables");

    a_irq_follows_lcv: assert property ( // [R11] [R17]
        @(posedge REF_CLK) disable iff (RST)
        (LCV_DETECT && s_r.evt_en[`EAEI_BIT_LCV] && s_r.blk_en && !WR) |=> IRQ)
        else $error("enabled line violation did not raise the interrupt");

    a_blk_mask_irq: assert property ( // [R16]
        @(posedge REF_CLK) disable iff (RST)
        (!s_r.blk_en && !WR) |=> !IRQ)
        else $error("interrupt raised while the group is masked");

    a_oof_clear_flag: assert property ( // [R3]
        @(posedge REF_CLK) disable iff (RST)
        (FAS_CHECK && !FAS_ERROR && s_r.oof && s_r.evt_en[`EAEI_BIT_OOF_CHG])
        |=> !OOF_STATE && s_r.flags[`EAEI_BIT_OOF_CHG])
        else $error("frame loss clear not latched");

    a_set_wins_clear: assert property ( // [R18]
        @(posedge REF_CLK) disable iff (RST)
        (rd_evt && LCV_DETECT) |=> s_r.flags[`EAEI_BIT_LCV] ##1 1'b1)
        else $error("event lost beside a clearing read");

endmodule : eaei_top

// [tb/eaei_tb_top.sv]
// Self-checking bench for the alarm and error interrupt block.
// Assumes the design files and eaei_defs.svh are on the include path.
`include "eaei_defs.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------------------
    logic REF_CLK = 1'b0;
    logic RST = 1'b1;
    logic [15:0] ADDR = 16'h0000;
    logic [7:0] WDATA = 8'h00;
    logic WR = 1'b0, RD = 1'b0, LCV_DETECT = 1'b0, FAS_CHECK = 1'b0, FAS_ERROR = 1'b0;
    logic NFAS_FRAME = 1'b0, NFAS_A_BIT = 1'b0;
    logic RX_AIS_STATE = 1'b0, RX_MYEL_STATE = 1'b0, RX_LOS_STATE = 1'b0;
    logic [7:0] RDATA;
    logic IRQ, OOF_STATE, YEL_STATE;
    int failures = 0; // Mismatches seen
    int n_tests = 0;  // Comparisons made

    // 125 MHz clock
    always #4 REF_CLK = ~REF_CLK;

    eaei_top eaei_top_i
    (
        .REF_CLK(REF_CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .IRQ(IRQ), .LCV_DETECT(LCV_DETECT), .FAS_CHECK(FAS_CHECK),
        .FAS_ERROR(FAS_ERROR), .NFAS_FRAME(NFAS_FRAME), .NFAS_A_BIT(NFAS_A_BIT),
        .RX_AIS_STATE(RX_AIS_STATE), .RX_MYEL_STATE(RX_MYEL_STATE),
        .RX_LOS_STATE(RX_LOS_STATE), .OOF_STATE(OOF_STATE), .YEL_STATE(YEL_STATE)
    );

    // ------------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------------
    // Counts and reports one comparison
    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Waits n edges, then lets their updates land
    task tick(input int n);
        repeat (n) @(posedge REF_CLK);
        #1;
    endtask : tick

    // One-cycle register write
    task wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge REF_CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge REF_CLK);
        WR <= 1'b0;
    endtask : wr

    // One-cycle read, data judged in the following cycle; lcv raises an event beside it
    task rdc(input logic [15:0] a, input logic [7:0] e, input logic lcv = 1'b0);
        @(posedge REF_CLK);
        ADDR <= a;
        RD <= 1'b1;
        LCV_DETECT <= lcv;
        @(posedge REF_CLK);
        RD <= 1'b0;
        LCV_DETECT <= 1'b0;
        #1;
        chk("rdata", e, RDATA);
    endtask : rdc

    // n pulses: k=0 alignment check, k=1 non-alignment frame, k=2 line violation
    task pulse(input int k, input logic v, input int n);
        repeat (n)
        begin
            @(posedge REF_CLK);
            FAS_CHECK <= (k == 0);
            NFAS_FRAME <= (k == 1);
            LCV_DETECT <= (k == 2);
            FAS_ERROR <= v;
            NFAS_A_BIT <= v;
            @(posedge REF_CLK);
            {FAS_CHECK, NFAS_FRAME, LCV_DETECT} <= 3'h0;
        end
        tick(3);
    endtask : pulse

    // Prints the counts and the verdict
    task test_done();
        $display("Comparisons %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : test_done

    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    // Reset values, access kinds and an unmapped place
    task sc_regs();
        rdc(`EAEI_OFS_EVT_STATUS, 8'h00);
        rdc(`EAEI_OFS_BLK_STATUS, 8'h00);
        rdc(`EAEI_OFS_BLK_ENABLE, 8'h00);
        rdc(`EAEI_OFS_EVT_ENABLE, 8'h00);
        wr(`EAEI_OFS_EVT_ENABLE, 8'hff);
        rdc(`EAEI_OFS_EVT_ENABLE, 8'h3f);
        wr(`EAEI_OFS_EVT_ENABLE, 8'hef);
        rdc(`EAEI_OFS_EVT_ENABLE, 8'h2f);
        wr(`EAEI_OFS_BLK_ENABLE, 8'h02);
        rdc(`EAEI_OFS_BLK_ENABLE, 8'h02);
        wr(16'h0b10, 8'hff);
        rdc(16'h0b10, 8'h00);
    endtask : sc_regs

    // Line violation, interrupt, clear on read, event beside the clearing read
    task sc_lcv();
        pulse(2, 1'b0, 1);
        chk("irq", 8'h01, {7'h00, IRQ});
        rdc(`EAEI_OFS_BLK_STATUS, 8'h02);
        rdc(`EAEI_OFS_EVT_STATUS, 8'h08);
        rdc(`EAEI_OFS_EVT_STATUS, 8'h00, 1'b1);
        rdc(`EAEI_OFS_EVT_STATUS, 8'h08);
        tick(1);
        chk("irq", 8'h00, {7'h00, IRQ});
    endtask : sc_lcv

    // Alarm signal and multiframe changes, then a disabled change
    task sc_levels();
        @(posedge REF_CLK);
        RX_AIS_STATE <= 1'b1;
        RX_MYEL_STATE <= 1'b1;
        RX_LOS_STATE <= 1'b1;
        tick(3);
        rdc(`EAEI_OFS_EVT_STATUS, 8'h72);
        wr(`EAEI_OFS_EVT_ENABLE, 8'h0d);
        RX_AIS_STATE <= 1'b0;
        RX_MYEL_STATE <= 1'b0;
        RX_LOS_STATE <= 1'b0;
        tick(3);
        rdc(`EAEI_OFS_EVT_STATUS, 8'h00);
        wr(`EAEI_OFS_EVT_ENABLE, 8'h2f);
    endtask : sc_levels

    // Frame loss after the programmed count of errored patterns, both edges
    task sc_oof();
        wr(`EAEI_OFS_FRM_CTRL, 8'hfb);
        rdc(`EAEI_OFS_FRM_CTRL, 8'h03);
        pulse(0, 1'b1, 2);
        chk("oof", 8'h00, {7'h00, OOF_STATE});
        pulse(0, 1'b1, 1);
        chk("oof", 8'h01, {7'h00, OOF_STATE});
        rdc(`EAEI_OFS_EVT_STATUS, 8'h84);
        pulse(0, 1'b0, 1);
        rdc(`EAEI_OFS_EVT_STATUS, 8'h04);
    endtask : sc_oof

    // Remote alarm declared and cleared by two equal A bits
    task sc_yel();
        pulse(1, 1'b1, 1);
        chk("yel", 8'h00, {7'h00, YEL_STATE});
        pulse(1, 1'b1, 1);
        chk("yel", 8'h01, {7'h00, YEL_STATE});
        rdc(`EAEI_OFS_EVT_ENABLE, 8'haf);
        rdc(`EAEI_OFS_EVT_STATUS, 8'h01);
        pulse(1, 1'b0, 2);
        rdc(`EAEI_OFS_EVT_ENABLE, 8'h2f);
        rdc(`EAEI_OFS_EVT_STATUS, 8'h01);
    endtask : sc_yel

    // Block enable masks the pin but not the pending bit
    task sc_mask();
        wr(`EAEI_OFS_BLK_ENABLE, 8'h00);
        pulse(2, 1'b0, 1);
        chk("irq", 8'h00, {7'h00, IRQ});
        rdc(`EAEI_OFS_BLK_STATUS, 8'h02);
        rdc(`EAEI_OFS_EVT_STATUS, 8'h08);
        rdc(`EAEI_OFS_BLK_STATUS, 8'h00);
        pulse(2, 1'b0, 1);
        wr(`EAEI_OFS_EVT_STATUS, 8'h00);
        rdc(`EAEI_OFS_BLK_STATUS, 8'h02);
        wr(`EAEI_OFS_EVT_STATUS, 8'h08);
        rdc(`EAEI_OFS_BLK_STATUS, 8'h00);
    endtask : sc_mask

    // ------------------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------------------
    initial
    begin
        repeat (8) @(posedge REF_CLK);
        RST <= 1'b0;
        sc_regs();
        sc_lcv();
        sc_levels();
        sc_oof();
        sc_yel();
        sc_mask();
        test_done();
    end

    // Cuts a hang short
    initial
    begin
        repeat (20000) @(posedge REF_CLK);
        failures++;
        test_done();
    end
endmodule : tb_top
